// *** hdl/ods_output_regs.v ***
// control registers for the line output stage, output muxes and dc servo
// How it works
// R1: bit 8 of the right line control register mutes the right line output.
// R2: writing 1 to the line volume update bit applies both line volumes at once.
// R3: bit 6 enables zero-cross gated volume changes on the right line output.
// R4: the 6-bit right volume code runs from -57dB at 0 in 1dB steps to +6dB.
// R5: bit 3 feeds the left headphone mux from the left pga instead of the dac.
// R6: bit 2 feeds the right headphone mux from the right pga instead of the dac.
// R7: bit 1 feeds the left line mux from the left pga instead of the dac.
// R8: bit 0 feeds the right line mux from the right pga instead of the dac.
// R9: the servo enable register holds one enable per output channel, bits 3:0.
// R10: writing 1 to trigger bits 15:12 starts one correction on that channel.
// R11: a single trigger bit reads 1 while its correction runs.
// R12: writing 1 to bit 11 starts a series of corrections on the right line.
// R13: a series trigger bit reads 1 while its series runs.
// R14: bits 10:8 are the series triggers of the other three channels.
// R15: a series performs the series count plus one updates, 1 to 128.
// R16: trigger bits clear when done, and writing 0 neither starts nor aborts.
// R17: a new right volume stays pending until the update bit is written with 1.
//
// Chosen here: the address-and-strobe port.
`include "ods_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module ods_output_regs (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire [7:0]  addr,
   input  wire [15:0] wr_data,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [15:0] rd_data,
   output reg         right_line_mute,
   output reg         right_line_zero_cross_enable,
   output reg  [5:0]  right_line_volume,
   output reg         left_line_mute,
   output reg         left_line_zero_cross_enable,
   output reg  [5:0]  left_line_volume,
   output reg         left_headphone_bypass_select,
   output reg         right_headphone_bypass_select,
   output reg         left_line_bypass_select,
   output reg         right_line_bypass_select,
   output reg  [3:0]  servo_channel_enable,
   output reg  [3:0]  servo_busy,
   output reg  [3:0]  servo_update,
   output reg         irq
);

   localparam CNT_W = 5;
   // last tick of one update, cut to the tick counter width on purpose
   localparam integer     UPD_CYC  = `ODS_UPD_CYCLES - 1;
   localparam [CNT_W-1:0] UPD_LAST = UPD_CYC[CNT_W-1:0];

   // pending volumes and control bits
   reg  [5:0]  r_vol_pend_q;
   reg  [5:0]  l_vol_pend_q;
   reg         r_mute_q;
   reg         r_zc_q;
   reg         l_mute_q;
   reg         l_zc_q;
   reg  [5:0]  r_vol_act_q;
   reg  [5:0]  l_vol_act_q;
   reg  [3:0]  bypass_q;
   reg  [3:0]  srv_ena_q;
   reg  [6:0]  ser_cnt23_q;
   reg  [6:0]  ser_cnt01_q;
   reg  [3:0]  irq_stat_q;
   reg  [3:0]  irq_mask_q;

   // servo engine state, one slot per channel
   reg  [3:0]       single_q;
   reg  [3:0]       series_q;
   reg  [7:0]       remain_q [0:3];
   reg  [CNT_W-1:0] tick_q   [0:3];
   reg  [3:0]       done_q;
   reg  [3:0]       upd_q;

   wire wr_l   = wr_stb && (addr == `ODS_OFF_LLINE);
   wire wr_r   = wr_stb && (addr == `ODS_OFF_RLINE);
   wire wr_trg = wr_stb && (addr == `ODS_OFF_SRV_TRIG);
   wire vu_hit = (wr_l || wr_r) && wr_data[`ODS_VU_BIT];

   // update count for a channel: series count plus one, 1..128
   function [7:0] series_len;
      input [1:0] ch;
      begin
         if (ch[1])
            series_len = {1'b0, ser_cnt23_q} + 8'h01;
         else
            series_len = {1'b0, ser_cnt01_q} + 8'h01;
      end
   endfunction

   // plain read/write registers
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         r_vol_pend_q <= `ODS_VOL_RST;
         l_vol_pend_q <= `ODS_VOL_RST;
         r_mute_q     <= 1'b0;
         r_zc_q       <= 1'b0;
         l_mute_q     <= 1'b0;
         l_zc_q       <= 1'b0;
         bypass_q     <= 4'h0;
         srv_ena_q    <= 4'h0;
         ser_cnt23_q  <= `ODS_SER_CNT_RST;
         ser_cnt01_q  <= `ODS_SER_CNT_RST;
         irq_mask_q   <= 4'h0;
      end else if (wr_stb) begin
         case (addr)
            `ODS_OFF_RLINE: begin
               r_mute_q     <= wr_data[`ODS_MUTE_BIT];  // see R1
               r_zc_q       <= wr_data[`ODS_ZC_BIT];    // see R3
               r_vol_pend_q <= wr_data[5:0];            // see R17
            end
            `ODS_OFF_LLINE: begin
               l_mute_q     <= wr_data[`ODS_MUTE_BIT];
               l_zc_q       <= wr_data[`ODS_ZC_BIT];
               l_vol_pend_q <= wr_data[5:0];
            end
            `ODS_OFF_BYPASS:    bypass_q    <= wr_data[3:0];
            `ODS_OFF_SRV_ENA:   srv_ena_q   <= wr_data[3:0];  // see R9
            `ODS_OFF_SER_CNT23: ser_cnt23_q <= wr_data[6:0];
            `ODS_OFF_SER_CNT01: ser_cnt01_q <= wr_data[6:0];
            `ODS_OFF_IRQ_MASK:  irq_mask_q  <= wr_data[3:0];
            default: begin
            end
         endcase
      end
   end

   // active volumes move only on a write with the update bit set
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         r_vol_act_q <= `ODS_VOL_RST;
         l_vol_act_q <= `ODS_VOL_RST;
      end else if (vu_hit) begin
         // both sides together; the word being written counts at once
         r_vol_act_q <= wr_r ? wr_data[5:0] : r_vol_pend_q;  // see R2, R17
         l_vol_act_q <= wr_l ? wr_data[5:0] : l_vol_pend_q;  // see R2
      end
   end

   // servo engine: each update lasts a fixed tick count
   integer i;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         single_q <= 4'h0;
         series_q <= 4'h0;
         done_q   <= 4'h0;
         upd_q    <= 4'h0;
         for (i = 0; i < 4; i = i + 1) begin
            remain_q[i] <= 8'h00;
            tick_q[i]   <= {CNT_W{1'b0}};
         end
      end else begin
         done_q <= 4'h0;
         upd_q  <= 4'h0;
         for (i = 0; i < 4; i = i + 1) begin
            if (single_q[i] || series_q[i]) begin
               // a running correction ignores further writes
               if (tick_q[i] == UPD_LAST) begin
                  tick_q[i]   <= {CNT_W{1'b0}};
                  upd_q[i]    <= 1'b1;
                  remain_q[i] <= remain_q[i] - 8'h01;
                  if (remain_q[i] == 8'h01) begin
                     single_q[i] <= 1'b0;  // see R16
                     series_q[i] <= 1'b0;  // see R16
                     done_q[i]   <= 1'b1;
                  end
               end else begin
                  tick_q[i] <= tick_q[i] + 1'b1;
               end
            end else if (wr_trg && wr_data[`ODS_SERIES_BASE + i]) begin
               series_q[i] <= 1'b1;  // see R12, R14
               remain_q[i] <= series_len(i[1:0]);  // see R15
               tick_q[i]   <= {CNT_W{1'b0}};
            end else if (wr_trg && wr_data[`ODS_SINGLE_BASE + i]) begin
               single_q[i] <= 1'b1;  // see R10
               remain_q[i] <= 8'h01;
               tick_q[i]   <= {CNT_W{1'b0}};
            end
         end
      end
   end

   // sticky completion status, cleared by reading it; a new event wins
   wire rd_stat = rd_stb && (addr == `ODS_OFF_IRQ_STAT);
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         irq_stat_q <= 4'h0;
      else
         irq_stat_q <= (irq_stat_q & {4{~rd_stat}}) | done_q;
   end

   // read mux, data valid the cycle after the strobe; unmapped reads zero
   reg [15:0] rd_mux;
   always @* begin
      rd_mux = 16'h0000;
      case (addr)
         `ODS_OFF_RLINE:
            rd_mux = {7'h00, r_mute_q, 1'b0, r_zc_q, r_vol_pend_q};
         `ODS_OFF_LLINE:
            rd_mux = {7'h00, l_mute_q, 1'b0, l_zc_q, l_vol_pend_q};
         `ODS_OFF_BYPASS:    rd_mux = {12'h000, bypass_q};
         `ODS_OFF_SRV_ENA:   rd_mux = {12'h000, srv_ena_q};
         `ODS_OFF_SRV_TRIG:
            rd_mux = {single_q, series_q, 8'h00};  // see R11, R13
         `ODS_OFF_SER_CNT23: rd_mux = {9'h000, ser_cnt23_q};
         `ODS_OFF_SER_CNT01: rd_mux = {9'h000, ser_cnt01_q};
         `ODS_OFF_IRQ_STAT:  rd_mux = {12'h000, irq_stat_q};
         `ODS_OFF_IRQ_MASK:  rd_mux = {12'h000, irq_mask_q};
         default:            rd_mux = 16'h0000;
      endcase
   end

   // registered outputs
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data                       <= 16'h0000;
         right_line_mute               <= 1'b0;
         right_line_zero_cross_enable  <= 1'b0;
         right_line_volume             <= `ODS_VOL_RST;
         left_line_mute                <= 1'b0;
         left_line_zero_cross_enable   <= 1'b0;
         left_line_volume              <= `ODS_VOL_RST;
         left_headphone_bypass_select  <= 1'b0;
         right_headphone_bypass_select <= 1'b0;
         left_line_bypass_select       <= 1'b0;
         right_line_bypass_select      <= 1'b0;
         servo_channel_enable          <= 4'h0;
         servo_busy                    <= 4'h0;
         servo_update                  <= 4'h0;
         irq                           <= 1'b0;
      end else begin
         rd_data                       <= rd_stb ? rd_mux : 16'h0000;
         right_line_mute               <= r_mute_q;      // see R1
         right_line_zero_cross_enable  <= r_zc_q;        // see R3
         right_line_volume             <= r_vol_act_q;   // see R4
         left_line_mute                <= l_mute_q;
         left_line_zero_cross_enable   <= l_zc_q;
         left_line_volume              <= l_vol_act_q;
         left_headphone_bypass_select  <= bypass_q[3];   // see R5
         right_headphone_bypass_select <= bypass_q[2];   // see R6
         left_line_bypass_select       <= bypass_q[1];   // see R7
         right_line_bypass_select      <= bypass_q[0];   // see R8
         servo_channel_enable          <= srv_ena_q;     // see R9
         servo_busy                    <= single_q | series_q;
         servo_update                  <= upd_q;
         irq                           <= |(irq_stat_q & irq_mask_q);
      end
   end

endmodule

`default_nettype wire

// *** shared/ods_defines.vh ***
// register offsets, field positions, reset values and timing counts
`ifndef ODS_DEFINES_VH
`define ODS_DEFINES_VH

// register offsets (8-bit control port address)
`define ODS_ADDR_W          8
`define ODS_DATA_W          16
`define ODS_OFF_LLINE       8'h3b
`define ODS_OFF_RLINE       8'h3c
`define ODS_OFF_BYPASS      8'h3d
`define ODS_OFF_SRV_ENA     8'h43
`define ODS_OFF_SRV_TRIG    8'h44
`define ODS_OFF_SER_CNT23   8'h47
`define ODS_OFF_SER_CNT01   8'h48
`define ODS_OFF_IRQ_STAT    8'h50
`define ODS_OFF_IRQ_MASK    8'h51

// line output control fields
`define ODS_MUTE_BIT        8
`define ODS_VU_BIT          7
`define ODS_ZC_BIT          6
`define ODS_VOL_MSB         5
`define ODS_VOL_LSB         0

// servo trigger fields: channel i sits at base + i
`define ODS_SINGLE_BASE     12
`define ODS_SERIES_BASE     8
`define ODS_SER_CNT_MSB     6

// reset values
`define ODS_VOL_RST         6'h39
`define ODS_SER_CNT_RST     7'h2a

// timing: one servo update lasts this long
`define ODS_CLK_NS          40
`define ODS_UPD_TIME_NS     640
`define ODS_UPD_CYCLES      (`ODS_UPD_TIME_NS / `ODS_CLK_NS)

`endif

// *** dv/ods_output_regs_assertions.sv ***
// port-level checks for the output stage register block
`timescale 1ns/1ps
`default_nettype none
module ods_regs_checker (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic [7:0]  addr,
   input wire logic [15:0] wr_data,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [15:0] rd_data,
   input wire logic        right_line_mute,
   input wire logic        right_line_zero_cross_enable,
   input wire logic [5:0]  right_line_volume,
   input wire logic        left_line_mute,
   input wire logic        left_line_zero_cross_enable,
   input wire logic [5:0]  left_line_volume,
   input wire logic        left_headphone_bypass_select,
   input wire logic        right_headphone_bypass_select,
   input wire logic        left_line_bypass_select,
   input wire logic        right_line_bypass_select,
   input wire logic [3:0]  servo_channel_enable,
   input wire logic [3:0]  servo_busy,
   input wire logic [3:0]  servo_update,
   input wire logic        irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // decoded write strobes
   wire w_r = wr_stb && addr == 8'h3c;
   wire w_vu = wr_stb && wr_data[7] && (addr == 8'h3b || w_r);
   wire [3:0] byp = {left_headphone_bypass_select,
      right_headphone_bypass_select, left_line_bypass_select,
      right_line_bypass_select};
   rd_idle_a: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
      else $error("read data not idle");
   mute_follow_a: assert property (w_r |-> ##2
      right_line_mute == $past(wr_data[8], 2)) else $error("mute wrong");
   zc_follow_a: assert property (w_r |-> ##2
      right_line_zero_cross_enable == $past(wr_data[6], 2))
      else $error("zero cross wrong");
   vol_apply_a: assert property (w_r && wr_data[7] |-> ##2
      right_line_volume == $past(wr_data[5:0], 2)) else $error("vol");
   vol_hold_a: assert property ($changed(right_line_volume) |->
      $past(w_vu, 2)) else $error("volume moved without update");
   bypass_follow_a: assert property (wr_stb && addr == 8'h3d |-> ##2
      byp == $past(wr_data[3:0], 2)) else $error("bypass wrong");
   srv_ena_a: assert property (wr_stb && addr == 8'h43 |-> ##2
      servo_channel_enable == $past(wr_data[3:0], 2)) else $error("enable");
   busy_start_a: assert property ($rose(servo_busy[0]) |->
      $past(wr_stb && addr == 8'h44 && (wr_data[12] || wr_data[8]), 2))
      else $error("busy without trigger");
   upd_pulse_a: assert property (servo_update[3] |=>
      !servo_update[3] [*8]) else $error("update pulses too close");
endmodule
bind ods_output_regs ods_regs_checker ods_regs_checker_inst (.*);
`default_nettype wire

// *** dv/tb_ods_output_regs.sv ***
// self-checking bench for the output stage and servo register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_ods_output_regs;
   logic        sys_clk = 0;
   logic        arst_n = 0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic        wr_stb = 0;
   logic        rd_stb = 0;
   wire  [15:0] rd_data;
   wire         right_line_mute, right_line_zero_cross_enable, irq;
   wire         left_line_mute, left_line_zero_cross_enable;
   wire  [5:0]  right_line_volume, left_line_volume;
   wire         left_headphone_bypass_select, right_headphone_bypass_select;
   wire         left_line_bypass_select, right_line_bypass_select;
   wire  [3:0]  servo_channel_enable, servo_busy, servo_update;
   int          err_count = 0, cmp_count = 0, cyc = 0, up0 = 0, up3 = 0, i;
   logic [15:0] d, e, q;
   logic [5:0]  act_r = 6'h39;
   logic [7:0]  adr [10] = '{8'h3b, 8'h3c, 8'h3d, 8'h43, 8'h44, 8'h47,
                             8'h48, 8'h50, 8'h51, 8'h40};
   logic [15:0] rv [10] = '{16'h39, 16'h39, 0, 0, 0, 16'h2a, 16'h2a, 0, 0, 0};
   wire  [3:0]  byp = {left_headphone_bypass_select,
      right_headphone_bypass_select, left_line_bypass_select,
      right_line_bypass_select};
   ods_output_regs ods_output_regs_inst (.*);
   always #20 sys_clk = ~sys_clk;
   // hang guard and servo update pulse counters
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      up0 <= up0 + servo_update[0];
      up3 <= up3 + servo_update[3];
      if (cyc == 20000) begin
         err_count++;
         stop_test;
      end
   end
   task automatic stop_test;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= v;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 v = rd_data;
   endtask
   // a written value reaches the pins two edges after it is taken
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   initial begin
      void'($urandom(32'hf912a90d));
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (i = 0; i < 10; i++) begin
         rd(adr[i], q);
         `CHK("reset value", rv[i], q)
      end
      for (i = 0; i < 12; i++) begin
         d = $urandom;
         d[7] = 1'b0;
         if (i < 2) d[5:0] = i ? 6'h3f : 6'h00;
         wr(8'h3c, d);
         settle;
         `CHK("mute", d[8], right_line_mute)
         `CHK("zero cross", d[6], right_line_zero_cross_enable)
         `CHK("held volume", act_r, right_line_volume)
         rd(8'h3c, q);
         `CHK("pending", {7'h0, d[8], 1'b0, d[6:0]}, q)
         e = $urandom | 16'h0080;
         wr(8'h3b, e);
         settle;
         act_r = d[5:0];
         `CHK("volumes", {e[5:0], act_r}, {left_line_volume, right_line_volume})
         `CHK("left mute", e[8], left_line_mute)
         `CHK("left zc", e[6], left_line_zero_cross_enable)
         d = $urandom;
         wr(8'h3d, d);
         wr(8'h43, ~d);
         settle;
         `CHK("bypass", d[3:0], byp)
         `CHK("servo enable", ~d[3:0], servo_channel_enable)
      end
      // right write carrying the update bit applies its own volume at once
      wr(8'h3c, 16'h00b0);
      settle;
      `CHK("applied", 6'h30, right_line_volume)
      // single on channel 0 and a two-update series on channel 3
      wr(8'h51, 16'h0001);
      wr(8'h47, 16'h0001);
      wr(8'h44, 16'h1800);
      repeat (3) @(posedge sys_clk);
      wr(8'h44, 16'h0000);
      wr(8'h44, 16'h1000);
      repeat (5) @(posedge sys_clk);
      rd(8'h44, q);
      `CHK("busy bits", 16'h1800, q)
      `CHK("busy pins", 4'h9, servo_busy)
      repeat (4) @(posedge sys_clk);
      rd(8'h44, q);
      `CHK("series busy", 16'h0800, q)
      `CHK("series pins", 4'h8, servo_busy)
      `CHK("irq raised", 1'b1, irq)
      rd(8'h50, q);
      `CHK("status ch0", 16'h0001, q)
      repeat (12) @(posedge sys_clk);
      rd(8'h44, q);
      `CHK("all idle", 16'h0000, q)
      `CHK("irq masked", 1'b0, irq)
      rd(8'h50, q);
      `CHK("status ch3", 16'h0008, q)
      `CHK("updates", {32'd1, 32'd2}, {up0, up3})
      arst_n <= 1'b0;
      settle;
      `CHK("volume in reset", 6'h39, right_line_volume)
      stop_test;
   end
endmodule
`default_nettype wire
